/* rtl/gp_pin_report_and_chip_reset.sv */
// Pin settings store, settings response tail (bytes 17..63) and chip reset command.
// Assumes command bytes arrive one per cycle in order, first byte flagged.
//
// Function
// - Response bytes 17..21 carry password bytes four to eight in order.
// - Byte 22 bit 4 is pin zero output level, driven when GPIO output.
// - Bit 3 picks direction, 1 input 0 output, only in GPIO mode.
// - Pin zero functions: GPIO, suspend indicator, receive LED; other codes ignored.
// - Byte 23 holds pin one settings; output bit driven when GPIO output.
// - Pin one: GPIO, clock reference, analog in one, transmit LED, edge detect.
// - Byte 24 holds pin two settings; output bit driven when GPIO output.
// - Pin two: GPIO, bus configured status, analog in two, analog out one.
// - Byte 25 holds pin three settings; output bit driven when GPIO output.
// - Pin three: GPIO, I2C LED, analog in three, analog out two.
// - First byte 0x70 with key bytes 1..3 correct forces full device reset; host zeroes bytes 4..63.
// - Reset command gets no response, nor do reports arriving during a chip reset; every other command gets one.
`timescale 1ns/1ps
`include "gp_report_map.svh"

module gp_pin_report_and_chip_reset (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	// Command report bytes
	input wire logic rx_valid_in,
	input wire logic rx_first_in,
	input wire logic [7:0] rx_byte_in,
	// Settings and password updates
	input wire logic cfg_write_in,
	input wire logic [1:0] cfg_pin_in,
	input wire logic [7:0] cfg_byte_in,
	input wire logic pwd_write_in,
	input wire logic [2:0] pwd_index_in,
	input wire logic [7:0] pwd_byte_in,
	// Response tail and chip reset
	input wire logic rsp_req_in,
	input wire logic tx_ready_in,
	output logic tx_valid_out,
	output logic [5:0] tx_index_out,
	output logic [7:0] tx_byte_out,
	output logic rsp_due_out,
	output logic chip_reset_out,
	// Alternate function sources
	input wire logic suspend_in,
	input wire logic clk_ref_in,
	input wire logic urx_led_in,
	input wire logic utx_led_in,
	input wire logic bus_cfg_in,
	input wire logic i2c_led_in,
	// Pins and unit enables
	output logic [3:0] pin_drive_out,
	output logic [3:0] pin_oe_out,
	output logic [2:0] analog_in_en_out,
	output logic [1:0] analog_out_en_out,
	output logic edge_detect_en_out
);

	localparam logic [4:0] RESET_CYC = 5'(`CHIP_RESET_CYC);

	pin_cfg_if cfg_if ();

	pin_function_decode u_decode (
		.cfg_if(cfg_if.decode),
		.suspend_in(suspend_in),
		.clk_ref_in(clk_ref_in),
		.urx_led_in(urx_led_in),
		.utx_led_in(utx_led_in),
		.bus_cfg_in(bus_cfg_in),
		.i2c_led_in(i2c_led_in)
	);

	gp_report_pkg::pin_cfg_t pin_cfg_q [4];
	gp_report_pkg::pin_cfg_t pin_cfg_d [4];
	logic [7:0] pwd_q [5];
	logic [7:0] pwd_d [5];
	gp_report_pkg::ctrl_state_e state_q;
	gp_report_pkg::ctrl_state_e state_d;
	logic [4:0] rst_cnt_q;
	logic soft_clear;

	assign cfg_if.cfg = pin_cfg_q;

	// ----------------------------------------------------------------
	// Settings and password store
	// ----------------------------------------------------------------
	// The end of a chip reset returns everything to its power-up value
	assign soft_clear = (state_q == gp_report_pkg::ST_RESET) && (rst_cnt_q == 5'h01);

	always_comb begin
		pin_cfg_d = pin_cfg_q;
		pwd_d = pwd_q;
		if (soft_clear) begin
			for (int k = 0; k < 4; k++) begin
				pin_cfg_d[k] = `PIN_CFG_RESET;
			end
			for (int k = 0; k < 5; k++) begin
				pwd_d[k] = 8'h00;
			end
		end else begin
			if (cfg_write_in) begin
				pin_cfg_d[cfg_pin_in] = cfg_byte_in[`PIN_OUT_BIT:0];
			end
			if (pwd_write_in && (pwd_index_in < 3'h5)) begin
				pwd_d[pwd_index_in] = pwd_byte_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			for (int k = 0; k < 4; k++) begin
				pin_cfg_q[k] <= `PIN_CFG_RESET;
			end
			for (int k = 0; k < 5; k++) begin
				pwd_q[k] <= 8'h00;
			end
		end else if (clk_en_in) begin
			pin_cfg_q <= pin_cfg_d;
			pwd_q <= pwd_d;
		end
	end

	// ----------------------------------------------------------------
	// Command report receiver
	// ----------------------------------------------------------------
	logic [5:0] rx_idx_q;
	logic [5:0] rx_idx_d;
	logic rx_active_q;
	logic rx_active_d;
	logic is_reset_q;
	logic is_reset_d;
	logic key_ok_q;
	logic key_ok_d;
	logic rx_done;
	logic rx_take;

	function automatic logic [7:0] key_byte(input logic [5:0] idx);
		case (idx)
			6'h01: key_byte = `CMD_KEY_1;
			6'h02: key_byte = `CMD_KEY_2;
			default: key_byte = `CMD_KEY_3;
		endcase
	endfunction : key_byte

	// Reports are ignored while a chip reset is under way
	assign rx_take = rx_valid_in && (state_q != gp_report_pkg::ST_RESET);
	assign rx_done = rx_take && rx_active_q && (rx_idx_q == `RPT_LAST);

	always_comb begin
		rx_idx_d = rx_idx_q;
		rx_active_d = rx_active_q;
		is_reset_d = is_reset_q;
		key_ok_d = key_ok_q;
		if (rx_take && rx_first_in) begin
			rx_idx_d = 6'h01;
			rx_active_d = 1'b1;
			is_reset_d = (rx_byte_in == `CMD_RESET_CODE);
			key_ok_d = 1'b1;
		end else if (rx_take && rx_active_q) begin
			rx_idx_d = rx_idx_q + 6'h01;
			if ((rx_idx_q >= `RPT_KEY_FIRST) && (rx_idx_q <= `RPT_KEY_LAST)
				&& (rx_byte_in != key_byte(rx_idx_q))) begin
				key_ok_d = 1'b0;
			end
			// Reserved bytes 4..63 are not checked, so stray values do no harm
			if (rx_idx_q == `RPT_LAST) begin
				rx_active_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rx_idx_q <= 6'h00;
			rx_active_q <= 1'b0;
			is_reset_q <= 1'b0;
			key_ok_q <= 1'b0;
		end else if (clk_en_in) begin
			rx_idx_q <= rx_idx_d;
			rx_active_q <= rx_active_d;
			is_reset_q <= is_reset_d;
			key_ok_q <= key_ok_d;
		end
	end

	// ----------------------------------------------------------------
	// Response and chip reset control
	// ----------------------------------------------------------------
	logic [4:0] rst_cnt_d;
	logic [5:0] tx_idx_q;
	logic [5:0] tx_idx_d;
	logic tx_valid_d;
	logic [7:0] tx_byte_d;
	logic rsp_due_d;
	logic chip_reset_d;
	logic tx_valid_q;
	logic [7:0] tx_byte_q;
	logic rsp_due_q;
	logic chip_reset_q;

	function automatic logic [7:0] rsp_byte(input logic [5:0] idx, input logic [7:0] pwd [5],
		input gp_report_pkg::pin_cfg_t cfg [4]);
		if ((idx >= `RSP_PWD_FIRST) && (idx <= `RSP_PWD_LAST)) begin
			rsp_byte = pwd[3'(idx - `RSP_PWD_FIRST)];
		end else if ((idx >= `RSP_PIN_FIRST) && (idx <= `RSP_PIN_LAST)) begin
			rsp_byte = {3'h0, cfg[2'(idx - `RSP_PIN_FIRST)]};
		end else begin
			rsp_byte = `RSP_FILL;
		end
	endfunction : rsp_byte

	always_comb begin
		state_d = state_q;
		rst_cnt_d = rst_cnt_q;
		tx_idx_d = tx_idx_q;
		tx_valid_d = tx_valid_q;
		tx_byte_d = tx_byte_q;
		rsp_due_d = 1'b0;
		chip_reset_d = chip_reset_q;
		case (state_q)
			gp_report_pkg::ST_IDLE: begin
				if (rx_done && is_reset_q && key_ok_q) begin
					// No response is raised for this command
					state_d = gp_report_pkg::ST_RESET;
					rst_cnt_d = RESET_CYC;
					chip_reset_d = 1'b1;
				end else begin
					rsp_due_d = rx_done;
					if (rsp_req_in) begin
						state_d = gp_report_pkg::ST_SEND;
						tx_idx_d = `RSP_PWD_FIRST;
						tx_valid_d = 1'b1;
						tx_byte_d = rsp_byte(`RSP_PWD_FIRST, pwd_q, pin_cfg_q);
					end
				end
			end
			gp_report_pkg::ST_SEND: begin
				// Commands finishing mid-send still owe their response
				rsp_due_d = rx_done && !(is_reset_q && key_ok_q);
				if (tx_ready_in) begin
					if (tx_idx_q == `RPT_LAST) begin
						state_d = gp_report_pkg::ST_IDLE;
						tx_valid_d = 1'b0;
						tx_idx_d = 6'h00;
						tx_byte_d = 8'h00;
					end else begin
						tx_idx_d = tx_idx_q + 6'h01;
						tx_byte_d = rsp_byte(tx_idx_q + 6'h01, pwd_q, pin_cfg_q);
					end
				end
				if (rx_done && is_reset_q && key_ok_q) begin
					// Reset wins over a response in progress
					state_d = gp_report_pkg::ST_RESET;
					rst_cnt_d = RESET_CYC;
					chip_reset_d = 1'b1;
					tx_valid_d = 1'b0;
					tx_idx_d = 6'h00;
					tx_byte_d = 8'h00;
				end
			end
			gp_report_pkg::ST_RESET: begin
				rst_cnt_d = rst_cnt_q - 5'h01;
				if (rst_cnt_q == 5'h01) begin
					state_d = gp_report_pkg::ST_IDLE;
					chip_reset_d = 1'b0;
				end
			end
			default: begin
				state_d = gp_report_pkg::ST_IDLE;
				chip_reset_d = 1'b0;
				tx_valid_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_q <= gp_report_pkg::ST_IDLE;
			rst_cnt_q <= 5'h00;
			tx_idx_q <= 6'h00;
			tx_valid_q <= 1'b0;
			tx_byte_q <= 8'h00;
			rsp_due_q <= 1'b0;
			chip_reset_q <= 1'b0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			rst_cnt_q <= rst_cnt_d;
			tx_idx_q <= tx_idx_d;
			tx_valid_q <= tx_valid_d;
			tx_byte_q <= tx_byte_d;
			rsp_due_q <= rsp_due_d;
			chip_reset_q <= chip_reset_d;
		end
	end

	assign tx_valid_out = tx_valid_q;
	assign tx_index_out = tx_idx_q;
	assign tx_byte_out = tx_byte_q;
	assign rsp_due_out = rsp_due_q;
	assign chip_reset_out = chip_reset_q;

	// ----------------------------------------------------------------
	// Pin and unit enable registers
	// ----------------------------------------------------------------
	// Registered so pins never glitch while settings change
	logic [3:0] drv_q;
	logic [3:0] oe_q;
	logic [2:0] ain_q;
	logic [1:0] aout_q;
	logic edge_q;
	logic [3:0] drv_d;
	logic [3:0] oe_d;
	logic [2:0] ain_d;
	logic [1:0] aout_d;
	logic edge_d;

	always_comb begin
		drv_d = cfg_if.drive;
		oe_d = cfg_if.oe;
		ain_d = cfg_if.ain_en;
		aout_d = cfg_if.aout_en;
		edge_d = cfg_if.edge_en;
		// Pins float while the chip is held in reset
		if (state_q == gp_report_pkg::ST_RESET) begin
			oe_d = 4'h0;
			ain_d = 3'h0;
			aout_d = 2'h0;
			edge_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			drv_q <= 4'h0;
			oe_q <= 4'h0;
			ain_q <= 3'h0;
			aout_q <= 2'h0;
			edge_q <= 1'b0;
		end else if (clk_en_in) begin
			drv_q <= drv_d;
			oe_q <= oe_d;
			ain_q <= ain_d;
			aout_q <= aout_d;
			edge_q <= edge_d;
		end
	end

	assign pin_drive_out = drv_q;
	assign pin_oe_out = oe_q;
	assign analog_in_en_out = ain_q;
	assign analog_out_en_out = aout_q;
	assign edge_detect_en_out = edge_q;

endmodule : gp_pin_report_and_chip_reset

/* rtl/gp_report_map.svh */
// Offsets, field positions, codes and timing counts for the pin report block.
// Assumes byte indices of a 64-byte report and a 200 MHz system clock.
`ifndef GP_REPORT_MAP_SVH
`define GP_REPORT_MAP_SVH

// ----------------------------------------------------------------
// Report byte indices
// ----------------------------------------------------------------
`define RSP_PWD_FIRST 6'h11
`define RSP_PWD_LAST 6'h15
`define RSP_PIN_FIRST 6'h16
`define RSP_PIN_LAST 6'h19
`define RPT_LAST 6'h3f
`define RPT_KEY_FIRST 6'h01
`define RPT_KEY_LAST 6'h03

// ----------------------------------------------------------------
// Pin settings byte fields
// ----------------------------------------------------------------
`define PIN_OUT_BIT 4
`define PIN_DIR_BIT 3
`define PIN_FUNC_MSB 2
`define PIN_CFG_RESET 5'h08
`define RSP_FILL 8'h00

// ----------------------------------------------------------------
// Function selection codes
// ----------------------------------------------------------------
`define FUNC_GPIO 3'h0
`define FUNC_DEDICATED 3'h1
`define FUNC_ALT0 3'h2
`define FUNC_ALT1 3'h3
`define FUNC_ALT2 3'h4

// ----------------------------------------------------------------
// Chip reset command
// ----------------------------------------------------------------
`define CMD_RESET_CODE 8'h70
`define CMD_KEY_1 8'hab
`define CMD_KEY_2 8'hcd
`define CMD_KEY_3 8'hef

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define CHIP_RESET_NS 100
`define CHIP_RESET_CYC ((`CHIP_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/gp_report_pkg.sv */
// Types shared by the pin report block and its pin function decoder.
// Assumes the constants of gp_report_map.svh.
package gp_report_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_RESET = 2'b10
	} ctrl_state_e;

	typedef logic [4:0] pin_cfg_t;
	typedef logic [5:0] byte_idx_t;

endpackage : gp_report_pkg

/* rtl/pin_cfg_if.sv */
// Carrier between the report block and the pin function decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps

interface pin_cfg_if;
	gp_report_pkg::pin_cfg_t cfg [4];
	logic [3:0] drive;
	logic [3:0] oe;
	logic [2:0] ain_en;
	logic [1:0] aout_en;
	logic edge_en;

	modport owner (
		output cfg,
		input drive,
		input oe,
		input ain_en,
		input aout_en,
		input edge_en
	);

	modport decode (
		input cfg,
		output drive,
		output oe,
		output ain_en,
		output aout_en,
		output edge_en
	);
endinterface : pin_cfg_if

/* rtl/pin_function_decode.sv */
// Combinational decode of the four pin settings into pin drive and unit enables.
// Assumes the owner registers every result before it leaves the chip.
`timescale 1ns/1ps
`include "gp_report_map.svh"

module pin_function_decode (
	pin_cfg_if.decode cfg_if,
	input wire logic suspend_in,
	input wire logic clk_ref_in,
	input wire logic urx_led_in,
	input wire logic utx_led_in,
	input wire logic bus_cfg_in,
	input wire logic i2c_led_in
);

	function automatic logic is_gpio(input gp_report_pkg::pin_cfg_t c);
		is_gpio = (c[`PIN_FUNC_MSB:0] == `FUNC_GPIO);
	endfunction : is_gpio

	logic [3:0] alt_drv;
	logic [3:0] alt_oe;

	// ----------------------------------------------------------------
	// Alternate functions per pin
	// ----------------------------------------------------------------
	always_comb begin
		alt_drv = 4'h0;
		alt_oe = 4'h0;
		cfg_if.ain_en = 3'h0;
		cfg_if.aout_en = 2'h0;
		cfg_if.edge_en = 1'b0;
		// Unused codes leave the pin undriven rather than guessing a function
		case (cfg_if.cfg[0][`PIN_FUNC_MSB:0])
			`FUNC_DEDICATED: begin alt_drv[0] = suspend_in; alt_oe[0] = 1'b1; end
			`FUNC_ALT0: begin alt_drv[0] = urx_led_in; alt_oe[0] = 1'b1; end
			default: ;
		endcase
		case (cfg_if.cfg[1][`PIN_FUNC_MSB:0])
			`FUNC_DEDICATED: begin alt_drv[1] = clk_ref_in; alt_oe[1] = 1'b1; end
			`FUNC_ALT0: cfg_if.ain_en[0] = 1'b1;
			`FUNC_ALT1: begin alt_drv[1] = utx_led_in; alt_oe[1] = 1'b1; end
			`FUNC_ALT2: cfg_if.edge_en = 1'b1;
			default: ;
		endcase
		case (cfg_if.cfg[2][`PIN_FUNC_MSB:0])
			`FUNC_DEDICATED: begin alt_drv[2] = bus_cfg_in; alt_oe[2] = 1'b1; end
			`FUNC_ALT0: cfg_if.ain_en[1] = 1'b1;
			`FUNC_ALT1: cfg_if.aout_en[0] = 1'b1;
			default: ;
		endcase
		case (cfg_if.cfg[3][`PIN_FUNC_MSB:0])
			`FUNC_DEDICATED: begin alt_drv[3] = i2c_led_in; alt_oe[3] = 1'b1; end
			`FUNC_ALT0: cfg_if.ain_en[2] = 1'b1;
			`FUNC_ALT1: cfg_if.aout_en[1] = 1'b1;
			default: ;
		endcase
	end

	// ----------------------------------------------------------------
	// GPIO or alternate drive per pin
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_pin
			// Direction counts only in GPIO mode; bit 3 set means input
			assign cfg_if.oe[i] = is_gpio(cfg_if.cfg[i]) ? ~cfg_if.cfg[i][`PIN_DIR_BIT] : alt_oe[i];
			assign cfg_if.drive[i] = is_gpio(cfg_if.cfg[i]) ? cfg_if.cfg[i][`PIN_OUT_BIT] : alt_drv[i];
		end
	endgenerate

endmodule : pin_function_decode

/* testbench/gp_pin_report_and_chip_reset_tb.sv */
// Self-checking bench for the pin report and chip reset block.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`include "gp_report_map.svh"

module gp_pin_report_and_chip_reset_tb;
	typedef struct packed {
		logic [1:0] pin;
		logic [7:0] cfg;
		logic [7:0] res;
	} row_s;
	// res is {oe, drive, analog in [2:0], analog out [1:0], edge}; alt sources all high
	row_s rows [22] = '{'{2'h0, 8'h10, 8'hc0}, '{2'h0, 8'h18, 8'h40}, '{2'h0, 8'he0, 8'h80},
		'{2'h0, 8'h01, 8'hc0}, '{2'h0, 8'h02, 8'hc0}, '{2'h0, 8'h07, 8'h00}, '{2'h1, 8'h01, 8'hc0},
		'{2'h1, 8'h02, 8'h08}, '{2'h1, 8'h03, 8'hc0}, '{2'h1, 8'h04, 8'h01}, '{2'h1, 8'h05, 8'h00},
		'{2'h1, 8'h08, 8'h00}, '{2'h2, 8'h01, 8'hc0}, '{2'h2, 8'h02, 8'h10}, '{2'h2, 8'h03, 8'h02},
		'{2'h2, 8'h04, 8'h00}, '{2'h2, 8'h08, 8'h00}, '{2'h3, 8'h01, 8'hc0}, '{2'h3, 8'h02, 8'h20},
		'{2'h3, 8'h03, 8'h04}, '{2'h3, 8'h04, 8'h00}, '{2'h3, 8'h18, 8'h40}};
	logic clk_in, resetn_in, clk_en_in, rx_valid_in, rx_first_in, tx_ready_in, cfg_write_in;
	logic pwd_write_in, rsp_req_in, tx_valid_out, rsp_due_out, chip_reset_out, edge_detect_en_out;
	logic go, key_ok, stall, busy;
	logic [7:0] rx_byte_in, cfg_byte_in, pwd_byte_in, tx_byte_out, code;
	logic [1:0] cfg_pin_in, analog_out_en_out;
	logic [2:0] pwd_index_in, analog_in_en_out;
	logic [5:0] tx_index_out, src, sidx;
	logic [3:0] pin_drive_out, pin_oe_out;
	logic [7:0] pwd_m [5];
	logic [7:0] cfg_m [4];
	int n_errors, checks, cycles;

	gp_pin_report_and_chip_reset dut (.*, .suspend_in(src[0]), .clk_ref_in(src[1]), .urx_led_in(src[2]),
		.utx_led_in(src[3]), .bus_cfg_in(src[4]), .i2c_led_in(src[5]));
	usb_host_model host (.clk_in(clk_in), .go_in(go), .code_in(code), .key_ok_in(key_ok), .stall_in(stall),
		.rx_valid_out(rx_valid_in), .rx_first_out(rx_first_in), .rx_byte_out(rx_byte_in),
		.tx_ready_out(tx_ready_in), .busy_out(busy));

	// ----
	// Tasks
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Leaves one extra cycle so the pin register has caught up
	task automatic cfg_wr(input logic [1:0] p, input logic [7:0] b);
		cfg_pin_in = p;
		cfg_byte_in = b;
		cfg_write_in = 1'b1;
		cfg_m[p] = b;
		tick(1);
		cfg_write_in = 1'b0;
		tick(1);
	endtask : cfg_wr
	task automatic get_rsp();
		int n;
		logic [7:0] e;
		n = 0;
		rsp_req_in = 1'b1;
		tick(1);
		rsp_req_in = 1'b0;
		for (int k = 0; k < 400 && n < 47; k++) begin
			if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
				e = (n < 5) ? pwd_m[n] : (n < 9) ? {3'h0, cfg_m[n - 5][4:0]} : 8'h00;
				chk({2'h0, tx_index_out, tx_byte_out}, {2'h0, 6'h11 + n[5:0], e});
				n++;
			end
			tick(1);
		end
		chk(16'(n), 16'h002f);
		chk({15'h0000, tx_valid_out}, 16'h0000);
	endtask : get_rsp
	task automatic cmd(input logic [7:0] c, input logic k, input logic [15:0] e_due, input logic [15:0] e_rst);
		int d;
		int r;
		d = 0;
		r = 0;
		code = c;
		key_ok = k;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		repeat (90) begin
			tick(1);
			d += (rsp_due_out === 1'b1);
			r += (chip_reset_out === 1'b1);
		end
		chk(16'(d), e_due);
		chk(16'(r), e_rst);
	endtask : cmd
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// ----
	// Stimulus
	// ----
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		{resetn_in, cfg_write_in, pwd_write_in, rsp_req_in, go, stall, code} = '0;
		{cfg_pin_in, cfg_byte_in, pwd_index_in, pwd_byte_in} = '0;
		{clk_en_in, key_ok, src} = 8'hff;
		pwd_m = '{default: 8'h00};
		cfg_m = '{default: 8'h08};
		tick(10);
		resetn_in = 1'b1;
		chk({pin_oe_out, pin_drive_out, analog_in_en_out, analog_out_en_out, edge_detect_en_out,
			tx_valid_out, chip_reset_out}, 16'h0000);
		foreach (rows[i]) begin
			cfg_wr(rows[i].pin, rows[i].cfg);
			chk({pin_oe_out[rows[i].pin], pin_drive_out[rows[i].pin], analog_in_en_out, analog_out_en_out,
				edge_detect_en_out}, {8'h00, rows[i].res});
		end
		get_rsp();
		// Slot 5 is beyond the password and must leave it alone
		pwd_write_in = 1'b1;
		for (int i = 0; i < 6; i++) begin
			pwd_index_in = 3'(i);
			pwd_byte_in = 8'ha0 + 8'(i);
			if (i < 5) pwd_m[i] = pwd_byte_in;
			tick(1);
		end
		pwd_write_in = 1'b0;
		cfg_wr(2'h0, 8'he2);
		cfg_wr(2'h1, 8'h14);
		cfg_wr(2'h2, 8'h0b);
		cfg_wr(2'h3, 8'h1c);
		stall = 1'b1;
		get_rsp();
		stall = 1'b0;
		get_rsp();
		rsp_req_in = 1'b1;
		tick(1);
		rsp_req_in = 1'b0;
		tick(3);
		clk_en_in = 1'b0;
		sidx = tx_index_out;
		tick(4);
		chk({10'h000, tx_index_out}, {10'h000, sidx});
		clk_en_in = 1'b1;
		tick(60);
		cmd(8'h10, 1'b1, 16'h0001, 16'h0000);
		cmd(8'h70, 1'b0, 16'h0001, 16'h0000);
		stall = 1'b1;
		rsp_req_in = 1'b1;
		tick(1);
		rsp_req_in = 1'b0;
		cmd(8'h70, 1'b1, 16'h0000, 16'(`CHIP_RESET_CYC));
		chk({15'h0000, tx_valid_out}, 16'h0000);
		stall = 1'b0;
		pwd_m = '{default: 8'h00};
		cfg_m = '{default: 8'h08};
		get_rsp();
		// Mid-run reset must drop the pins and restore default settings
		cfg_wr(2'h1, 8'h10);
		tick(1);
		resetn_in = 1'b0;
		tick(2);
		resetn_in = 1'b1;
		chk({pin_oe_out, pin_drive_out, analog_in_en_out, analog_out_en_out, edge_detect_en_out,
			tx_valid_out, chip_reset_out}, 16'h0000);
		cfg_m = '{default: 8'h08};
		get_rsp();
		print_verdict();
	end
endmodule : gp_pin_report_and_chip_reset_tb

/* testbench/gp_report_asserts.sv */
// Concurrent checks on the ports of the pin report and chip reset block.
// Assumes one clk_in domain; bound into the block's top module at the foot.
`timescale 1ns/1ps

module gp_report_asserts (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	input wire logic rx_valid_in,
	input wire logic rsp_req_in,
	input wire logic tx_ready_in,
	input wire logic cfg_write_in,
	input wire logic [1:0] cfg_pin_in,
	input wire logic [7:0] cfg_byte_in,
	input wire logic tx_valid_out,
	input wire logic [5:0] tx_index_out,
	input wire logic [7:0] tx_byte_out,
	input wire logic rsp_due_out,
	input wire logic chip_reset_out,
	input wire logic [3:0] pin_drive_out,
	input wire logic [3:0] pin_oe_out,
	input wire logic [2:0] analog_in_en_out,
	input wire logic edge_detect_en_out
);
	// ----
	// Helpers
	// ----
	logic [4:0] run_q;
	logic [4:0] run_d;
	logic rx_q;
	logic rx_d;
	logic go;
	always_comb begin
		run_d = !chip_reset_out ? 5'h00 : clk_en_in ? run_q + 5'h01 : run_q;
		rx_d = rx_valid_in;
	end
	always_ff @(posedge clk_in) begin
		run_q <= resetn_in ? run_d : 5'h00;
		rx_q <= resetn_in ? rx_d : 1'b0;
	end
	// A command finishing within two cycles may abort the response, so skip those
	assign go = clk_en_in && !rx_valid_in && !rx_q && !chip_reset_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// ----
	// Properties
	// ----
	a_rsp_start: assert property (go && rsp_req_in && !tx_valid_out |=> tx_valid_out && tx_index_out == 6'h11)
		else $error("response did not open at byte 17");
	a_index_step: assert property (go && tx_valid_out && tx_ready_in && tx_index_out < 6'h3f
		|=> tx_valid_out && tx_index_out == $past(tx_index_out) + 6'h01)
		else $error("response index did not step");
	a_last_byte: assert property (go && tx_valid_out && tx_ready_in && tx_index_out == 6'h3f
		|=> !tx_valid_out && tx_index_out == 6'h00 && tx_byte_out == 8'h00)
		else $error("response did not end after byte 63");
	a_byte_hold: assert property (go && tx_valid_out && !tx_ready_in
		|=> tx_valid_out && $stable(tx_index_out) && $stable(tx_byte_out))
		else $error("offered byte changed while stalled");
	a_tail_zero: assert property (tx_valid_out && tx_index_out > 6'h19 |-> tx_byte_out == 8'h00)
		else $error("tail byte not zero");
	a_pin_spare: assert property (tx_valid_out && tx_index_out inside {[6'h16:6'h19]} |-> tx_byte_out[7:5] == 3'h0)
		else $error("pin byte upper bits not zero");
	a_reset_len: assert property ($fell(chip_reset_out) |-> run_q == 5'h14)
		else $error("chip reset length wrong");
	a_reset_quiet: assert property (chip_reset_out |=> !rsp_due_out && !tx_valid_out && pin_oe_out == 4'h0)
		else $error("activity during chip reset");
	a_due_pulse: assert property (clk_en_in && rsp_due_out |=> !rsp_due_out)
		else $error("response due held over one cycle");
	a_gpio_pin: assert property (cfg_write_in && clk_en_in && cfg_byte_in[2:0] == 3'h0
		|-> ##2 pin_oe_out[$past(cfg_pin_in, 2)] == !$past(cfg_byte_in[3], 2)
		&& pin_drive_out[$past(cfg_pin_in, 2)] == $past(cfg_byte_in[4], 2))
		else $error("GPIO pin not per settings");
	a_edge_sel: assert property (cfg_write_in && clk_en_in && cfg_pin_in == 2'h1 && cfg_byte_in[2:0] == 3'h4
		|-> ##2 edge_detect_en_out && !pin_oe_out[1] && analog_in_en_out == 3'h0)
		else $error("edge detect not selected");
	c_reset_done: cover property ($fell(chip_reset_out));
	c_last_byte: cover property (tx_valid_out && tx_ready_in && tx_index_out == 6'h3f);
	c_due: cover property (rsp_due_out);
endmodule : gp_report_asserts

bind gp_pin_report_and_chip_reset gp_report_asserts chk_i (.*);

/* testbench/usb_host_model.sv */
// Host side stand-in: sends 64-byte command reports and accepts response bytes.
// Assumes go_in is raised for one cycle shortly after a rising edge.
`timescale 1ns/1ps

module usb_host_model (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] code_in,
	input wire logic key_ok_in,
	input wire logic stall_in,
	output logic rx_valid_out,
	output logic rx_first_out,
	output logic [7:0] rx_byte_out,
	output logic tx_ready_out,
	output logic busy_out
);
	logic tog_q = 1'b0;
	function automatic logic [7:0] byte_at(input int i);
		if (i == 0) return code_in;
		if (i > 3) return 8'h00;
		byte_at = (i == 1) ? 8'hab : (i == 2) ? 8'hcd : 8'hef;
		// A broken key is only sent when the bench asks for it
		if (!key_ok_in) byte_at = ~byte_at;
	endfunction : byte_at
	always @(posedge clk_in) tog_q <= ~tog_q;
	// Stalling accepts a byte only on every other cycle
	assign tx_ready_out = !stall_in || tog_q;
	initial begin
		rx_valid_out = 1'b0;
		rx_first_out = 1'b0;
		rx_byte_out = 8'h5a;
		busy_out = 1'b0;
		forever begin
			@(posedge clk_in);
			if (go_in) begin
				busy_out = 1'b1;
				for (int i = 0; i < 64; i++) begin
					#1;
					rx_valid_out = 1'b1;
					rx_first_out = (i == 0);
					rx_byte_out = byte_at(i);
					@(posedge clk_in);
				end
				busy_out = 1'b0;
			end
			// Idle data never repeats its last value
			#1;
			rx_valid_out = 1'b0;
			rx_first_out = 1'b0;
			rx_byte_out = ~rx_byte_out;
		end
	end
endmodule : usb_host_model
